/* File: ext_display_consts.svh */
`ifndef EXT_DISPLAY_CONSTS_SVH
`define EXT_DISPLAY_CONSTS_SVH

// ************************************************************
// Register index and reset value
// ************************************************************
`define EXT_DISP_CTRL_INDEX   8'h1b
`define EXT_DISP_CTRL_RESET   8'h64

// ************************************************************
// Field positions of extended_display_control
// ************************************************************
`define BIT_BLANK_EXT_EN      7
`define BIT_TEXT_FAST_PAGE    6
`define BIT_BLANK_CTRL        5
`define BIT_OFFSET_MSB        4
`define BIT_START_A18         3
`define BIT_START_A17         2
`define BIT_ADDR_WRAP         1
`define BIT_START_A16         0

// ************************************************************
// Field positions of misc_timing_control
// ************************************************************
`define MISC_VBE_HI           7
`define MISC_VBE_LO           6
`define MISC_HBE_HI           5
`define MISC_HBE_LO           4

// ************************************************************
// Address counter widths
// ************************************************************
`define ADDR_WIDTH_NARROW     16
`define ADDR_WIDTH_WIDE       19

`endif

/* File: ext_display_pkg.sv */
// ************************************************************
// Shared types
// ************************************************************
package ext_display_pkg;
  // Memory cycle style for text fetches
  typedef enum logic [0:0] {
    FETCH_RANDOM = 1'b0,
    FETCH_FAST   = 1'b1
  } fetch_mode_e;

  // DAC blanking source
  typedef enum logic [0:0] {
    BLANK_FROM_CRTC   = 1'b0,
    BLANK_FROM_DISPEN = 1'b1
  } blank_src_e;
endpackage : ext_display_pkg

/* File: fetch_mode_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Fetch mode hand-off between register and gating stage
// ************************************************************
interface fetch_mode_if;
  logic requested;   // Bit as software wrote it
  logic ras_idle;    // Both row strobes high (synchronised)
  logic applied;     // Mode actually used by the fetch logic
  modport owner (output requested, output ras_idle, input applied);
  modport gate  (input requested, input ras_idle, output applied);
endinterface : fetch_mode_if
`default_nettype wire

/* File: fetch_mode_gate.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ext_display_consts.svh"
// ************************************************************
// Holds the applied fast-page mode until row strobes are idle
// ************************************************************
module fetch_mode_gate (
  input  wire logic   clk_in,
  input  wire logic   rstn_in,
  fetch_mode_if.gate  fm
);
  logic applied_reg;   // Mode in use
  logic applied_next;  // Next mode

  // Next value: only follow the request while no row strobe is active
  always_comb begin
    applied_next = applied_reg;
    if (fm.ras_idle) begin
      applied_next = fm.requested;
    end
  end

  // Register, reset to the fast-page bit of the register reset value
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      applied_reg <= 1'(`EXT_DISP_CTRL_RESET >> `BIT_TEXT_FAST_PAGE);
    end else begin
      applied_reg <= applied_next;
    end
  end

  assign fm.applied = applied_reg;
endmodule : fetch_mode_gate
`default_nettype wire

/* File: extended_display_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ext_display_consts.svh"
module extended_display_control (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Indexed host port
  input  wire logic [7:0]  index_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  wr_data_in,
  output logic      [7:0]  rd_data_out,
  // Neighbouring register contents
  input  wire logic [7:0]  misc_timing_control_in,
  input  wire logic [7:0]  row_offset_low_reg_in,
  input  wire logic [15:0] start_address_low_in,
  input  wire logic [5:0]  hblank_end_low_in,
  input  wire logic [7:0]  vblank_end_low_in,
  input  wire logic        attribute_graphics_select_in,
  // Video timing sources
  input  wire logic        crtc_blank_in,
  input  wire logic        display_enable_in,
  input  wire logic [1:0]  ras_n_in,
  // Derived controls
  output logic             blank_ext_active_out,
  output logic             text_fast_page_out,
  output logic             dac_blank_out,
  output logic             border_enable_out,
  output logic             overlay_window_out,
  output logic             overlay_window_oe_n_out,
  output logic [8:0]       row_offset_out,
  output logic [18:0]      start_address_out,
  output logic             addr_wrap_wide_out,
  output logic [4:0]       char_addr_width_out,
  output logic [7:0]       hblank_end_out,
  output logic [9:0]       vblank_end_out
);
  import ext_display_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0]  ctrl_reg;        // extended_display_control
  logic [7:0]  ctrl_next;
  logic [1:0]  ras_meta_reg;    // First synchroniser stage
  logic [1:0]  ras_sync_reg;    // Second synchroniser stage
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        ext_reg;
  logic        ext_next;
  logic        fast_reg;
  logic        fast_next;
  logic        dac_reg;
  logic        dac_next;
  logic        border_reg;
  logic        border_next;
  logic        ovr_reg;
  logic        ovr_next;
  logic        ovr_oe_n_reg;
  logic        ovr_oe_n_next;
  logic [8:0]  offset_reg;
  logic [8:0]  offset_next;
  logic [18:0] start_reg;
  logic [18:0] start_next;
  logic        wrap_reg;
  logic        wrap_next;
  logic [4:0]  width_reg;
  logic [4:0]  width_next;
  logic [7:0]  hbe_reg;
  logic [7:0]  hbe_next;
  logic [9:0]  vbe_reg;
  logic [9:0]  vbe_next;
  logic        ext_on;          // Extension fields in use
  blank_src_e  blank_src;       // Chosen DAC blanking source
  fetch_mode_e fetch_mode;      // Applied text fetch mode

  fetch_mode_if fm ();

  // ************************************************************
  // Fast-page gating stage
  // ************************************************************
  fetch_mode_gate u_gate (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .fm      (fm)
  );

  assign fm.requested = ctrl_reg[`BIT_TEXT_FAST_PAGE];
  assign fm.ras_idle  = &ras_sync_reg;

  // ************************************************************
  // Host register access
  // ************************************************************
  // Next register value from host writes
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_en_in && (index_in == `EXT_DISP_CTRL_INDEX)) begin
      ctrl_next = wr_data_in;
    end
  end

  // ************************************************************
  // Derived controls
  // ************************************************************
  // Compute every decoded output
  always_comb begin
    ext_on     = ctrl_reg[`BIT_BLANK_EXT_EN] | ctrl_reg[`BIT_BLANK_CTRL];
    blank_src  = blank_src_e'(ctrl_reg[`BIT_BLANK_CTRL]);
    fetch_mode = fetch_mode_e'(fm.applied);
    rd_data_next = (index_in == `EXT_DISP_CTRL_INDEX) ? ctrl_reg : 8'h00;
    ext_next   = ext_on;
    fast_next  = !attribute_graphics_select_in && (fetch_mode == FETCH_FAST);
    if (blank_src == BLANK_FROM_DISPEN) begin
      dac_next      = !display_enable_in;
      border_next   = 1'b0;
      ovr_next      = crtc_blank_in;
      ovr_oe_n_next = 1'b0;
    end else begin
      dac_next      = crtc_blank_in;
      border_next   = 1'b1;
      ovr_next      = 1'b0;
      ovr_oe_n_next = 1'b1;
    end
    offset_next = {ctrl_reg[`BIT_OFFSET_MSB], row_offset_low_reg_in};
    start_next  = {ctrl_reg[`BIT_START_A18], ctrl_reg[`BIT_START_A17],
                   ctrl_reg[`BIT_START_A16], start_address_low_in};
    wrap_next   = ctrl_reg[`BIT_ADDR_WRAP];
    width_next  = wrap_next ? 5'(`ADDR_WIDTH_WIDE) : 5'(`ADDR_WIDTH_NARROW);
    hbe_next = {ext_on ? misc_timing_control_in[`MISC_HBE_HI:`MISC_HBE_LO] : 2'h0,
                hblank_end_low_in};
    vbe_next = {ext_on ? misc_timing_control_in[`MISC_VBE_HI:`MISC_VBE_LO] : 2'h0,
                vblank_end_low_in};
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // All state, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl_reg     <= `EXT_DISP_CTRL_RESET;
      ras_meta_reg <= 2'h3;
      ras_sync_reg <= 2'h3;
      rd_data_reg  <= 8'h00;
      ext_reg      <= 1'b0;
      fast_reg     <= 1'b0;
      dac_reg      <= 1'b0;
      border_reg   <= 1'b0;
      ovr_reg      <= 1'b0;
      ovr_oe_n_reg <= 1'b1;
      offset_reg   <= 9'h000;
      start_reg    <= 19'h00000;
      wrap_reg     <= 1'b0;
      width_reg    <= 5'h10;
      hbe_reg      <= 8'h00;
      vbe_reg      <= 10'h000;
    end else begin
      ctrl_reg     <= ctrl_next;
      ras_meta_reg <= ras_n_in;
      ras_sync_reg <= ras_meta_reg;
      rd_data_reg  <= rd_data_next;
      ext_reg      <= ext_next;
      fast_reg     <= fast_next;
      dac_reg      <= dac_next;
      border_reg   <= border_next;
      ovr_reg      <= ovr_next;
      ovr_oe_n_reg <= ovr_oe_n_next;
      offset_reg   <= offset_next;
      start_reg    <= start_next;
      wrap_reg     <= wrap_next;
      width_reg    <= width_next;
      hbe_reg      <= hbe_next;
      vbe_reg      <= vbe_next;
    end
  end

  assign rd_data_out             = rd_data_reg;
  assign blank_ext_active_out    = ext_reg;
  assign text_fast_page_out      = fast_reg;
  assign dac_blank_out           = dac_reg;
  assign border_enable_out       = border_reg;
  assign overlay_window_out      = ovr_reg;
  assign overlay_window_oe_n_out = ovr_oe_n_reg;
  assign row_offset_out          = offset_reg;
  assign start_address_out       = start_reg;
  assign addr_wrap_wide_out      = wrap_reg;
  assign char_addr_width_out     = width_reg;
  assign hblank_end_out          = hbe_reg;
  assign vblank_end_out          = vbe_reg;
endmodule : extended_display_control
`default_nettype wire

/* File: ext_display_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Checker on the derived display controls
// ****************************************
module ext_display_sva (
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic [7:0] misc_timing_control_in,
  input wire logic       attribute_graphics_select_in,
  input wire logic       crtc_blank_in,
  input wire logic       display_enable_in,
  input wire logic [1:0] ras_n_in,
  input wire logic       blank_ext_active_out,
  input wire logic       text_fast_page_out,
  input wire logic       dac_blank_out,
  input wire logic       border_enable_out,
  input wire logic       overlay_window_out,
  input wire logic       overlay_window_oe_n_out,
  input wire logic       addr_wrap_wide_out,
  input wire logic [4:0] char_addr_width_out,
  input wire logic [7:0] hblank_end_out,
  input wire logic [9:0] vblank_end_out
);
  logic [1:0] age_reg;  // Edges seen since reset release
  // Outputs are trusted from the second edge after release
  always_ff @(posedge clk_in) begin
    age_reg <= rstn_in ? {age_reg[0], 1'b1} : 2'h0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_dac_from_crtc: assert property (
    age_reg[1] && border_enable_out |-> dac_blank_out == $past(crtc_blank_in))
    else $error("dac blank not from crtc blank");
  a_dac_from_enable: assert property (
    age_reg[1] && !overlay_window_oe_n_out |-> dac_blank_out == !$past(display_enable_in))
    else $error("dac blank not from display enable");
  a_overlay_follows_blank: assert property (
    age_reg[1] && !overlay_window_oe_n_out |-> overlay_window_out == $past(crtc_blank_in))
    else $error("overlay pin not following blank");
  a_overlay_drive_mode: assert property (
    age_reg[1] |-> overlay_window_oe_n_out == border_enable_out)
    else $error("overlay drive and border disagree");
  a_ext_when_off: assert property (
    age_reg[1] && !blank_ext_active_out |-> hblank_end_out[7:6] == 2'h0
    && vblank_end_out[9:8] == 2'h0) else $error("extension bits leak");
  a_ext_when_on: assert property (
    age_reg[1] && blank_ext_active_out |->
    {vblank_end_out[9:8], hblank_end_out[7:6]} == $past(misc_timing_control_in[7:4]))
    else $error("extension bits not applied");
  a_ext_by_bit5: assert property (
    age_reg[1] && !border_enable_out |-> blank_ext_active_out)
    else $error("bit five does not enable extensions");
  a_width_by_wrap: assert property (
    age_reg[1] |-> char_addr_width_out == (addr_wrap_wide_out ? 5'h13 : 5'h10))
    else $error("counter width wrong");
  a_fast_held_busy: assert property (
    (age_reg[1] && ras_n_in != 2'h3 && !attribute_graphics_select_in)[*6]
    ##1 !attribute_graphics_select_in |-> $stable(text_fast_page_out))
    else $error("fast page changed while busy");
  c_overlay_driven: cover property (!overlay_window_oe_n_out);
  c_fast_rise: cover property ($rose(text_fast_page_out));
  c_wide_wrap: cover property (addr_wrap_wide_out);
endmodule : ext_display_sva
bind extended_display_control ext_display_sva ext_display_sva_inst (.clk_in, .rstn_in,
  .misc_timing_control_in, .attribute_graphics_select_in, .crtc_blank_in,
  .display_enable_in, .ras_n_in, .blank_ext_active_out, .text_fast_page_out,
  .dac_blank_out, .border_enable_out, .overlay_window_out, .overlay_window_oe_n_out,
  .addr_wrap_wide_out, .char_addr_width_out, .hblank_end_out, .vblank_end_out);
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host software on the indexed port
// ****************************************
module host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_out,
  output logic      [7:0] index_in,
  output logic            wr_en_in,
  output logic      [7:0] wr_data_in
);
  initial begin
    index_in = 8'h00;
    wr_en_in = 1'b0;
    wr_data_in = 8'h00;
  end
  // One-cycle write strobe, data scrambled once released
  task automatic write(input logic [7:0] idx, input logic [7:0] val);
    @(posedge clk_in);
    index_in <= idx;
    wr_en_in <= 1'b1;
    wr_data_in <= val;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    wr_data_in <= ~val;
  endtask : write
  // Index held until the registered read data is taken
  task automatic read(input logic [7:0] idx, output logic [7:0] val);
    @(posedge clk_in);
    index_in <= idx;
    repeat (2) @(posedge clk_in);
    #1 val = rd_data_out;
  endtask : read
endmodule : host_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Register and derived control tests
// ****************************************
module testbench;
  logic clk_in = 1'b0, rstn_in = 1'b0, wr_en_in, attribute_graphics_select_in = 1'b0;
  logic crtc_blank_in = 1'b0, display_enable_in = 1'b0, blank_ext_active_out;
  logic text_fast_page_out, dac_blank_out, border_enable_out, overlay_window_out;
  logic overlay_window_oe_n_out, addr_wrap_wide_out;
  logic [1:0] ras_n_in = 2'h3;
  logic [7:0] index_in, wr_data_in, rd_data_out, misc_timing_control_in = 8'hb0;
  logic [7:0] hblank_end_out, got, v;
  logic [1:0] tprev;  // Timing inputs as the design last sampled them
  logic [9:0] vblank_end_out;
  logic [8:0] row_offset_out;
  logic [18:0] start_address_out;
  logic [4:0] char_addr_width_out;
  logic [7:0] vals [4] = '{8'h00, 8'hff, 8'h9a, 8'h65};  // Every bit both ways
  int fails = 0, n_tests = 0;
  always #10 clk_in = ~clk_in;
  // Video timing inputs walk through all combinations
  always @(posedge clk_in) begin
    {display_enable_in, crtc_blank_in} <= {display_enable_in, crtc_blank_in} + 2'h1;
  end
  extended_display_control extended_display_control_inst (.clk_in, .rstn_in, .index_in,
    .wr_en_in, .wr_data_in, .rd_data_out, .misc_timing_control_in,
    .row_offset_low_reg_in(8'h5c), .start_address_low_in(16'h1234),
    .hblank_end_low_in(6'h2a), .vblank_end_low_in(8'h3c), .attribute_graphics_select_in,
    .crtc_blank_in, .display_enable_in, .ras_n_in, .blank_ext_active_out,
    .text_fast_page_out, .dac_blank_out, .border_enable_out, .overlay_window_out,
    .overlay_window_oe_n_out, .row_offset_out, .start_address_out, .addr_wrap_wide_out,
    .char_addr_width_out, .hblank_end_out, .vblank_end_out);
  host_model host_model_inst (.clk_in, .rd_data_out, .index_in, .wr_en_in, .wr_data_in);
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // Watchdog against a hung sequence
  initial begin
    repeat (2000) @(posedge clk_in);
    fails++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    host_model_inst.read(8'h1b, got);
    check(got, 8'h64);
    check(start_address_out, 19'h21234);
    foreach (vals[i]) begin
      v = vals[i];
      host_model_inst.write(8'h1b, v);
      host_model_inst.read(8'h1b, got);
      check(got, v);
      check(start_address_out, {v[3:2], v[0], 16'h1234});
      check(row_offset_out, {v[4], 8'h5c});
      check(char_addr_width_out, v[1] ? 5'h13 : 5'h10);
      check({border_enable_out, overlay_window_oe_n_out}, {2{!v[5]}});
      check(blank_ext_active_out, v[7] | v[5]);
      check(hblank_end_out, {(v[7] | v[5]) ? 2'h3 : 2'h0, 6'h2a});
      check(vblank_end_out, {(v[7] | v[5]) ? 2'h2 : 2'h0, 8'h3c});
      check(addr_wrap_wide_out, v[1]);
      tprev = {display_enable_in, crtc_blank_in} - 2'h1;
      check(dac_blank_out, v[5] ? !tprev[1] : tprev[0]);
      check(overlay_window_out, v[5] & tprev[0]);
    end
    host_model_inst.write(8'h1a, 8'h00);
    host_model_inst.read(8'h1b, got);
    check(got, 8'h65);
    host_model_inst.read(8'h1a, got);
    check(got, 8'h00);
    check(text_fast_page_out, 1'b1);
    @(posedge clk_in);
    attribute_graphics_select_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 check(text_fast_page_out, 1'b0);
    @(posedge clk_in);
    attribute_graphics_select_in <= 1'b0;
    ras_n_in <= 2'h1;
    host_model_inst.write(8'h1b, 8'h25);
    repeat (8) @(posedge clk_in);
    #1 check(text_fast_page_out, 1'b1);
    @(posedge clk_in);
    ras_n_in <= 2'h3;
    repeat (8) @(posedge clk_in);
    #1 check(text_fast_page_out, 1'b0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
